// ==== design/gpio_ports_map.vh ====
// Constants for the shared-pin parallel I/O ports: selects, masks, resets.
`ifndef GPIO_PORTS_MAP_VH
`define GPIO_PORTS_MAP_VH

// Register selects; bit 2 set marks the high-page pin control group.
`define SEL_DATA        3'h0
`define SEL_DIR         3'h1
`define SEL_PULLUP      3'h4
`define SEL_SLEW        3'h5
`define SEL_DRIVE       3'h6
`define SEL_PAGE_BIT    2

// Number of ports and pins per port.
`define NUM_PORTS       3'h7
`define PORT_BITS       8
`define ALL_BITS        56

// Bonded pins, port G in the top byte down to port A in the bottom byte.
`define IMPL_MASK       56'h7f_73_ff_8e_3f_0f_87
// Pins with a shared analog converter input (ports B and D).
`define ANA_MASK        56'h00_00_00_8e_00_0f_00
// Pins whose direction a digital peripheral may take over (ports B to F).
`define ALT_DIR_MASK    56'h00_73_ff_8e_3f_0f_00
// Pins whose output data a digital peripheral may take over (C, E, F).
`define ALT_DATA_MASK   56'h00_73_ff_00_3f_00_00

// Reset values.
`define RST_DATA        56'h00_00_00_00_00_00_00
`define RST_DIR         56'h00_00_00_00_00_00_00
`define RST_PULLUP      56'h00_00_00_00_00_00_00
`define RST_SLEW        `IMPL_MASK
`define RST_DRIVE       56'h00_00_00_00_00_00_00

`endif

// ==== design/pin_sync.v ====
// Two-stage synchroniser for the asynchronous pin levels.
`timescale 1ns/100ps
module pin_sync #(
	parameter WIDTH = 56
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;

// The first stage feeds only the second, so metastability stays contained.
always @(posedge clk) begin
	if (!rst_n) begin
		meta_ff  <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else begin
		meta_ff  <= async_in;
		sync_out <= meta_ff;
	end
end

endmodule // pin_sync

// ==== design/gpio_ports.v ====
// Parallel I/O ports A to G with peripheral and analog pin overrides.
`timescale 1ns/100ps
`include "gpio_ports_map.vh"
module gpio_ports (
	input  wire        REF_CLK,
	input  wire        NRST,
	input  wire        WR_STB,
	input  wire [2:0]  WR_SEL,
	input  wire [2:0]  WR_PORT,
	input  wire [7:0]  WR_DATA,
	input  wire        RD_STB,
	input  wire [2:0]  RD_SEL,
	input  wire [2:0]  RD_PORT,
	output reg  [7:0]  RD_DATA,
	output reg         RD_VALID,
	input  wire [55:0] ALT_EN,
	input  wire [55:0] ALT_OUT_EN,
	input  wire [55:0] ALT_OUT_DATA,
	input  wire [55:0] ANA_EN,
	input  wire [55:0] PIN_IN,
	output wire [55:0] PIN_LEVEL,
	output reg  [55:0] PIN_OUT,
	output reg  [55:0] PIN_OE_N,
	output reg  [55:0] PIN_PULLUP,
	output reg  [55:0] PIN_SLEW,
	output reg  [55:0] PIN_DRIVE
);

////////////////////////////////////////////////////////////////////////////////

// Returns the byte of one port; a port number past G reads as zero.
function [7:0] get_byte;
	input [55:0] vec;
	input [2:0]  port;
	integer      i;
	begin
		get_byte = 8'h00;
		for (i = 0; i < 7; i = i + 1) begin
			if (port == i[2:0]) begin
				get_byte = vec[i*8 +: 8];
			end
		end
	end
endfunction

// Replaces one port's byte, keeping unbonded bits at zero.
function [55:0] put_byte;
	input [55:0] vec;
	input [2:0]  port;
	input [7:0]  val;
	integer      i;
	begin
		put_byte = vec;
		for (i = 0; i < 7; i = i + 1) begin
			if (port == i[2:0]) begin
				put_byte[i*8 +: 8] = val & get_byte(`IMPL_MASK, port);
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg  [55:0] data_ff;
reg  [55:0] dir_ff;
reg  [55:0] pullup_ff;
reg  [55:0] slew_ff;
reg  [55:0] drive_ff;
reg  [55:0] nxt_data;
reg  [55:0] nxt_dir;
reg  [55:0] nxt_pullup;
reg  [55:0] nxt_slew;
reg  [55:0] nxt_drive;
wire [55:0] pin_sync_q;
wire [55:0] ana_on;
wire [55:0] alt_dir_on;
wire [55:0] alt_data_on;
wire [55:0] out_en;
wire [55:0] out_val;
wire [55:0] read_view;
wire        port_ok_wr;
reg  [7:0]  nxt_rd_data;

pin_sync #(
	.WIDTH    (`ALL_BITS)
) u_pin_sync (
	.clk      (REF_CLK),
	.rst_n    (NRST),
	.async_in (PIN_IN),
	.sync_out (pin_sync_q)
);

assign PIN_LEVEL = pin_sync_q;

////////////////////////////////////////////////////////////////////////////////

// Only bonded pins in ports that share them see overrides; A and G have none.
// Analog enable shuts out digital overrides on the same pin.
assign ana_on      = ANA_EN & `ANA_MASK & `IMPL_MASK;
assign alt_dir_on  = ALT_EN & `ALT_DIR_MASK & `IMPL_MASK &
	~ana_on;

// Direction: analog forces input, an enabled peripheral decides, else the bit.
// Ports B to F share one mask; peripheral identity is the enable source.
assign out_en = ~ana_on & `IMPL_MASK &
	((alt_dir_on & ALT_OUT_EN) |
	(~alt_dir_on & dir_ff));

// Output data from the function only where it owns the data path.
assign alt_data_on = alt_dir_on & ALT_OUT_EN & `ALT_DATA_MASK;
assign out_val     = (alt_data_on & ALT_OUT_DATA) |
	(~alt_data_on & data_ff);

// Read view follows the direction bit even under a peripheral override.
assign read_view = ~ana_on &
	((dir_ff & data_ff) | (~dir_ff & pin_sync_q));

// A write to port seven is dropped so that it never aliases onto port A.
assign port_ok_wr = WR_STB & (WR_PORT < `NUM_PORTS);

////////////////////////////////////////////////////////////////////////////////

always @* begin
	nxt_data   = data_ff;
	nxt_dir    = dir_ff;
	nxt_pullup = pullup_ff;
	nxt_slew   = slew_ff;
	nxt_drive  = drive_ff;
	if (port_ok_wr) begin
		if (!WR_SEL[`SEL_PAGE_BIT]) begin
			// Zero-page group.
			if (WR_SEL == `SEL_DATA) begin
				nxt_data = put_byte(data_ff, WR_PORT, WR_DATA);
			end
			if (WR_SEL == `SEL_DIR) begin
				nxt_dir = put_byte(dir_ff, WR_PORT, WR_DATA);
			end
		end else begin
			// High-page pin control group.
			if (WR_SEL == `SEL_PULLUP) begin
				nxt_pullup = put_byte(pullup_ff, WR_PORT, WR_DATA);
			end
			if (WR_SEL == `SEL_SLEW) begin
				nxt_slew = put_byte(slew_ff, WR_PORT, WR_DATA);
			end
			if (WR_SEL == `SEL_DRIVE) begin
				nxt_drive = put_byte(drive_ff, WR_PORT, WR_DATA);
			end
		end
	end
end

// Unused selects and port seven read as zero, never as stale data.
always @* begin
	nxt_rd_data = 8'h00;
	case (RD_SEL)
		`SEL_DATA:   nxt_rd_data = get_byte(read_view, RD_PORT);
		`SEL_DIR:    nxt_rd_data = get_byte(dir_ff, RD_PORT);
		`SEL_PULLUP: nxt_rd_data = get_byte(pullup_ff, RD_PORT);
		`SEL_SLEW:   nxt_rd_data = get_byte(slew_ff, RD_PORT);
		`SEL_DRIVE:  nxt_rd_data = get_byte(drive_ff, RD_PORT);
		default:     nxt_rd_data = 8'h00;
	endcase
end

////////////////////////////////////////////////////////////////////////////////

// Pin outputs are registered, so pins follow a change one cycle later.
always @(posedge REF_CLK) begin
	if (!NRST) begin
		data_ff    <= `RST_DATA;
		dir_ff     <= `RST_DIR;
		pullup_ff  <= `RST_PULLUP;
		slew_ff    <= `RST_SLEW;
		drive_ff   <= `RST_DRIVE;
		RD_DATA    <= 8'h00;
		RD_VALID   <= 1'b0;
		PIN_OUT    <= 56'h00_00_00_00_00_00_00;
		PIN_OE_N   <= {`ALL_BITS{1'b1}};
		PIN_PULLUP <= `RST_PULLUP;
		PIN_SLEW   <= `RST_SLEW;
		PIN_DRIVE  <= `RST_DRIVE;
	end else begin
		data_ff    <= nxt_data;
		dir_ff     <= nxt_dir;
		pullup_ff  <= nxt_pullup;
		slew_ff    <= nxt_slew;
		drive_ff   <= nxt_drive;
		RD_VALID   <= RD_STB;
		if (RD_STB) begin
			RD_DATA <= nxt_rd_data;
		end
		PIN_OUT    <= out_val & out_en;
		PIN_OE_N   <= ~out_en;
		PIN_PULLUP <= pullup_ff & ~out_en & ~ana_on &
			`IMPL_MASK;
		PIN_SLEW   <= slew_ff;
		PIN_DRIVE  <= drive_ff;
	end
end

endmodule // gpio_ports

// ==== sim/gpio_ports_properties.sv ====
// Port-level checks for the shared-pin parallel I/O ports.
`timescale 1ns/100ps
`include "gpio_ports_map.vh"
module gpio_ports_properties (
	input wire        REF_CLK,
	input wire        NRST,
	input wire        RD_STB,
	input wire [2:0]  RD_PORT,
	input wire [7:0]  RD_DATA,
	input wire        RD_VALID,
	input wire [55:0] ALT_EN,
	input wire [55:0] ALT_OUT_EN,
	input wire [55:0] ALT_OUT_DATA,
	input wire [55:0] ANA_EN,
	input wire [55:0] PIN_OUT,
	input wire [55:0] PIN_OE_N,
	input wire [55:0] PIN_PULLUP,
	input wire [55:0] PIN_SLEW,
	input wire [55:0] PIN_DRIVE
);
	reg         rst_ff;
	wire [55:0] ana = ANA_EN & `ANA_MASK;
	wire [55:0] alt = ALT_EN & `ALT_DIR_MASK & ~ana;
	wire [55:0] alt_dat = alt & ALT_OUT_EN & `ALT_DATA_MASK;
	// Pins still hold reset state one edge after reset is released.
	always @(posedge REF_CLK) rst_ff <= !NRST;
	sequence s_rd_req; RD_STB; endsequence
	sequence s_rd_ans; RD_VALID; endsequence
	sequence s_rd_bad; RD_STB && RD_PORT == 3'h7; endsequence
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	////////////////////////////////////////
	AST_RST_DIR: assert property (
		rst_ff |-> &PIN_OE_N && PIN_OUT == 56'h0) else $error("reset dir");
	AST_RST_CTRL: assert property (
		rst_ff |-> PIN_SLEW == `RST_SLEW && PIN_DRIVE == 56'h0 &&
		PIN_PULLUP == 56'h0) else $error("reset ctrl");
	AST_ANA_OFF: assert property (1'b1 |=>
		((~PIN_OE_N | PIN_OUT | PIN_PULLUP) & $past(ana)) == 56'h0)
		else $error("analog pin not released");
	AST_ALT_DIR: assert property (1'b1 |=>
		((PIN_OE_N ^ ~$past(ALT_OUT_EN)) & $past(alt)) == 56'h0)
		else $error("peripheral direction lost");
	AST_ALT_DATA: assert property (1'b1 |=>
		((PIN_OUT ^ $past(ALT_OUT_DATA)) & $past(alt_dat)) == 56'h0)
		else $error("peripheral data lost");
	AST_PULL_OUT: assert property (
		(PIN_PULLUP & ~PIN_OE_N) == 56'h0) else $error("pullup on output");
	AST_RD_ANS: assert property (s_rd_req |=> s_rd_ans)
		else $error("read not answered");
	AST_RD_ONLY: assert property (
		RD_VALID |-> $past(RD_STB)) else $error("spurious read answer");
	AST_RD_HOLD: assert property (
		!RD_STB |=> $stable(RD_DATA)) else $error("read data moved");
	AST_RD_P7: assert property (s_rd_bad |=> RD_DATA == 8'h0)
		else $error("port seven read");
endmodule // gpio_ports_properties
bind gpio_ports gpio_ports_properties gpio_ports_properties_i (.REF_CLK,
	.NRST, .RD_STB, .RD_PORT, .RD_DATA, .RD_VALID, .ALT_EN, .ALT_OUT_EN,
	.ALT_OUT_DATA, .ANA_EN, .PIN_OUT, .PIN_OE_N, .PIN_PULLUP, .PIN_SLEW,
	.PIN_DRIVE);

// ==== sim/periph_board.sv ====
// Model of the sharing peripherals and the board around the pins.
`timescale 1ns/100ps
module periph_board (
	input  wire        mode,
	input  wire [55:0] board,
	input  wire [55:0] pin_out,
	input  wire [55:0] pin_oe_n,
	input  wire [55:0] pin_pullup,
	output wire [55:0] alt_en,
	output wire [55:0] alt_out_en,
	output wire [55:0] alt_out_data,
	output wire [55:0] ana_en,
	output wire [55:0] pin_in
);
	// Mode 1 claims pins on ports B to F; port B mixes analog and timer.
	assign alt_en = mode ? 56'h00_73_ff_8e_3f_0f_00 : 56'h0;
	assign alt_out_en = mode ? 56'h00_03_ff_00_0f_0f_00 : 56'h0;
	assign alt_out_data = mode ? 56'h00_01_3c_00_05_00_00 : 56'h0;
	assign ana_en = mode ? 56'h00_00_00_00_00_03_00 : 56'h0;
	// Released pins settle to the board resistors or the pullup.
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pullup | board));
endmodule // periph_board

// ==== sim/tb_gpio_ports.sv ====
// Self-checking bench for the shared-pin parallel I/O ports.
`timescale 1ns/100ps
`include "gpio_ports_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_gpio_ports;
	logic        REF_CLK = 1'b0, NRST = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
	logic [2:0]  WR_SEL = 3'h0, WR_PORT = 3'h0, RD_SEL = 3'h0, RD_PORT = 3'h0;
	logic [7:0]  WR_DATA = 8'h0;
	logic        mode = 1'b0;
	wire  [7:0]  RD_DATA;
	wire         RD_VALID;
	wire  [55:0] ALT_EN, ALT_OUT_EN, ALT_OUT_DATA, ANA_EN, PIN_IN, PIN_LEVEL;
	wire  [55:0] PIN_OUT, PIN_OE_N, PIN_PULLUP, PIN_SLEW, PIN_DRIVE;
	int          n_mismatch = 0, n_checks = 0, p;
	always #10 REF_CLK = ~REF_CLK;
	gpio_ports gpio_ports_i (.REF_CLK, .NRST, .WR_STB, .WR_SEL, .WR_PORT,
		.WR_DATA, .RD_STB, .RD_SEL, .RD_PORT, .RD_DATA, .RD_VALID, .ALT_EN,
		.ALT_OUT_EN, .ALT_OUT_DATA, .ANA_EN, .PIN_IN, .PIN_LEVEL, .PIN_OUT,
		.PIN_OE_N, .PIN_PULLUP, .PIN_SLEW, .PIN_DRIVE);
	periph_board periph_board_i (.mode(mode), .board(56'h30_00_00),
		.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .pin_pullup(PIN_PULLUP),
		.alt_en(ALT_EN), .alt_out_en(ALT_OUT_EN), .alt_out_data(ALT_OUT_DATA),
		.ana_en(ANA_EN), .pin_in(PIN_IN));
	////////////////////////////////////////
	task automatic idle(input int n);
		repeat (n) @(negedge REF_CLK);
	endtask
	task automatic wr(input [2:0] s, input [2:0] pt, input [7:0] d);
		@(negedge REF_CLK);
		{WR_STB, WR_SEL, WR_PORT, WR_DATA} = {1'b1, s, pt, d};
		@(negedge REF_CLK);
		WR_STB = 1'b0;
	endtask
	task automatic rd(input [2:0] s, input [2:0] pt, input [7:0] e);
		@(negedge REF_CLK);
		{RD_STB, RD_SEL, RD_PORT} = {1'b1, s, pt};
		@(negedge REF_CLK);
		RD_STB = 1'b0;
		`CHK(RD_VALID, 1'b1)
		`CHK(RD_DATA, e)
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		idle(12);
		NRST = 1'b1;
		idle(1);
		`CHK({PIN_OE_N, PIN_SLEW}, {{56{1'b1}}, `RST_SLEW})
		`CHK({PIN_DRIVE, PIN_PULLUP, PIN_OUT}, 168'h0)
		for (p = 0; p < 7; p++) begin
			rd(3'h5, p[2:0], 8'(`IMPL_MASK >> (p * 8)));
			rd(3'h1, p[2:0], 8'h00);
		end
		$display("reset test done");
		wr(3'h4, 3'h0, 8'hff);
		wr(3'h0, 3'h0, 8'ha5);
		wr(3'h1, 3'h0, 8'hff);
		idle(1);
		`CHK({PIN_OE_N[7:0], PIN_OUT[7:0]}, 16'h78_85)
		`CHK(PIN_PULLUP[7:0], 8'h00)
		rd(3'h0, 3'h0, 8'h85);
		wr(3'h1, 3'h0, 8'h00);
		idle(4);
		`CHK(PIN_PULLUP[7:0], 8'h87)
		rd(3'h0, 3'h0, 8'h87);
		wr(3'h6, 3'h4, 8'hff);
		wr(3'h6, 3'h7, 8'hff);
		idle(1);
		`CHK(PIN_DRIVE, 56'hff_00_00_00_00)
		rd(3'h6, 3'h7, 8'h00);
		rd(3'h2, 3'h4, 8'h00);
		$display("pin control test done");
		wr(3'h0, 3'h1, 8'h0f);
		wr(3'h1, 3'h1, 8'h0f);
		wr(3'h1, 3'h3, 8'hff);
		wr(3'h1, 3'h0, 8'hff);
		mode = 1'b1;
		idle(4);
		`CHK(PIN_OE_N, 56'hff_fc_00_ff_f0_f3_78)
		`CHK(PIN_OUT, 56'h00_01_3c_00_05_0c_85)
		rd(3'h0, 3'h1, 8'h0c);
		rd(3'h0, 3'h3, 8'h00);
		rd(3'h0, 3'h2, 8'h35);
		`CHK(PIN_LEVEL[23:16], 8'h35)
		mode = 1'b0;
		idle(2);
		`CHK(PIN_OE_N[23:8], 16'hff_f0)
		$display("override test done");
		NRST = 1'b0;
		idle(2);
		`CHK({PIN_DRIVE, PIN_PULLUP, PIN_OUT}, 168'h0)
		`CHK(PIN_OE_N, {56{1'b1}})
		NRST = 1'b1;
		idle(1);
		rd(3'h6, 3'h4, 8'h00);
		rd(3'h1, 3'h0, 8'h00);
		$display("second reset test done");
		final_report;
	end
	initial begin
		#20000;
		n_mismatch++;
		final_report;
	end
endmodule // tb_gpio_ports
